/* src/cbsr_pkg.sv */
// constants, types and carriers of the clock buffer smbus register block
package cbsr_pkg;
   // register indices
   localparam logic [6:0] REG_CTRL     = 7'h00;
   localparam logic [6:0] REG_OE_LOW   = 7'h01;
   localparam logic [6:0] REG_OE_HIGH  = 7'h02;
   localparam logic [6:0] REG_OE_RB_LO = 7'h03;
   localparam logic [6:0] REG_OE_RB_HI = 7'h04;
   // control byte field positions
   localparam int CTRL_FS       = 0;
   localparam int CTRL_SW_MODE  = 1;
   localparam int CTRL_SW_EN    = 3;
   localparam int CTRL_STRAP_PL = 6;
   // reset values
   localparam logic [1:0]  RST_SW_MODE = 2'h3;
   localparam logic        RST_SW_EN   = 1'h0;
   localparam logic [11:0] RST_OE      = 12'hFFF;
   // edges after reset release before the strap pipeline holds the pins
   localparam logic [1:0]  STRAP_SETTLE = 2'h2;
   // block transfer figures
   localparam logic [7:0] BLK_CNT_MAX = 8'h20;
   localparam logic [7:0] READ_COUNT  = 8'h05;
   localparam logic [3:0] BITS_BYTE   = 4'h8;
   // position of the byte within a transaction
   localparam logic [1:0] BYTE_ADDR = 2'h0;
   localparam logic [1:0] BYTE_CMD  = 2'h1;
   localparam logic [1:0] BYTE_CNT  = 2'h2;
   localparam logic [1:0] BYTE_DATA = 2'h3;
   // pll bandwidth encoding
   localparam logic [1:0] PLL_NARROW = 2'h0;
   localparam logic [1:0] PLL_BYPASS = 2'h1;
   localparam logic [1:0] PLL_WIDE   = 2'h3;

   typedef enum logic [2:0] {
      PH_IDLE, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK
   } cbsr_phase_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } cbsr_bus_s;

   typedef struct packed {
      logic [11:0] diff_clock_output_en;
      logic [1:0]  pll_mode;
      logic        frequency_select_bit;
   } cbsr_cfg_s;

   typedef struct packed {
      cbsr_bus_s   sync1;
      cbsr_bus_s   sync2;
      cbsr_bus_s   prev;
      logic [2:0]  strap1;
      logic [2:0]  strap2;
      logic        captured;
      logic [1:0]  settle;
      logic        strap_fs;
      logic [1:0]  strap_pll;
      logic [1:0]  sw_mode;
      logic        sw_en;
      logic [11:0] oe;
      logic [1:0]  pll_mode;
      cbsr_phase_e phase;
      logic [3:0]  bitcnt;
      logic [1:0]  byte_no;
      logic        rd;
      logic        blk_ok;
      logic [6:0]  index;
      logic [7:0]  sh;
      logic        sda_oe;
   } cbsr_state_s;
endpackage : cbsr_pkg

/* src/cbsr_regs.sv */
// smbus block read/write slave holding the clock buffer control bytes
//
// Summary of operation
// - block read command byte has msb zero, acked
// - read returns count 1..32 then data
// - write command low seven bits give index
// - command zero starts storing at register zero
// - every written byte is acknowledged
// - bit 0 reads strapped frequency select
// - bits 2:1 software mode, bit 3 enable
// - pll mode follows strap until enable set
// - software mode uses strap encoding
// - encoding 00 narrow, 01 bypass, 11 wide
// - bits 7:6 always read strapped mode
// - byte 1 enables outputs 0 to 7
// - byte 2 low nibble enables outputs 8-11
// - bytes 3,4 and bits 5:4 read zero
`timescale 1ns/1ps
module cbsr_regs #(
   parameter logic [6:0] SLAVE_ADDR = 7'h35  // arbitrary default
) (
   input  wire logic            sys_clk,
   input  wire logic            reset_n,
   input  wire cbsr_pkg::cbsr_bus_s smbus_in,
   input  wire logic            freq_select_strap,
   input  wire logic [1:0]      pll_bandwidth_strap,
   output logic                 sda_out,
   output logic                 sda_oe,
   output cbsr_pkg::cbsr_cfg_s  cfg_out
);
   import cbsr_pkg::*;

   // the fixed read count must be a legal block count
   if (READ_COUNT == 8'h00 || READ_COUNT > BLK_CNT_MAX) begin : g_bad_count
      $error("read count out of range");
   end

   cbsr_state_s s_r;
   cbsr_state_s s_nxt;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        load_data;
   logic [7:0]  rd_v;

   // ************************************************
   // register readback
   // ************************************************
   function automatic logic [7:0] rd_byte(input cbsr_state_s s,
                                          input logic [6:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         REG_CTRL: begin
            v[CTRL_FS]                = s.strap_fs;
            v[CTRL_SW_MODE +: 2]      = s.sw_mode;
            v[CTRL_SW_EN]             = s.sw_en;
            v[CTRL_STRAP_PL +: 2]     = s.strap_pll;
         end
         REG_OE_LOW:  v = s.oe[7:0];
         REG_OE_HIGH: v[3:0] = s.oe[11:8];
         default:     v = 8'h00;
      endcase
      return v;
   endfunction : rd_byte

   // ************************************************
   // bus conditions
   // ************************************************
   assign scl_rise = s_r.sync2.scl & ~s_r.prev.scl;
   assign scl_fall = ~s_r.sync2.scl & s_r.prev.scl;
   assign start_c  = s_r.sync2.scl & s_r.prev.scl
                     & ~s_r.sync2.sda & s_r.prev.sda;
   assign stop_c   = s_r.sync2.scl & s_r.prev.scl
                     & s_r.sync2.sda & ~s_r.prev.sda;
   assign load_data = s_r.phase == PH_TX_ACK && scl_fall && !s_r.sda_oe
                      && s_r.byte_no == BYTE_DATA;
   assign rd_v = rd_byte(s_r, s_r.index);

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      s_nxt        = s_r;
      s_nxt.sync1  = smbus_in;
      s_nxt.sync2  = s_r.sync1;
      s_nxt.prev   = s_r.sync2;
      s_nxt.strap1 = {freq_select_strap, pll_bandwidth_strap};
      s_nxt.strap2 = s_r.strap1;
      // wait until the strap pipeline holds pin levels, not reset zeros
      if (!s_r.captured) begin
         if (s_r.settle == STRAP_SETTLE) begin
            s_nxt.captured  = 1'b1;
            s_nxt.strap_fs  = s_r.strap2[2];
            s_nxt.strap_pll = s_r.strap2[1:0];
         end else begin
            s_nxt.settle = s_r.settle + 2'h1;
         end
      end
      // software bits use the strap encoding once enabled
      s_nxt.pll_mode = s_r.sw_en ? s_r.sw_mode
                                 : s_r.strap_pll;
      if (start_c) begin
         s_nxt.phase   = PH_RX;
         s_nxt.bitcnt  = 4'h0;
         s_nxt.byte_no = BYTE_ADDR;
         s_nxt.sda_oe  = 1'b0;
      end else if (stop_c) begin
         s_nxt.phase  = PH_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         unique case (s_r.phase)
            PH_IDLE: ;
            PH_RX: begin
               if (scl_rise && s_r.bitcnt != BITS_BYTE) begin
                  s_nxt.sh     = {s_r.sh[6:0], s_r.sync2.sda};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end else if (scl_fall && s_r.bitcnt == BITS_BYTE) begin
                  s_nxt.phase  = PH_RX_ACK;
                  s_nxt.sda_oe = 1'b1;
                  unique case (s_r.byte_no)
                     BYTE_ADDR: begin
                        s_nxt.rd = s_r.sh[0];
                        if (s_r.sh[7:1] != SLAVE_ADDR) begin
                           s_nxt.phase  = PH_IDLE;
                           s_nxt.sda_oe = 1'b0;
                        end
                     end
                     BYTE_CMD: begin
                        s_nxt.index  = s_r.sh[6:0];
                        s_nxt.blk_ok = ~s_r.sh[7];
                        s_nxt.byte_no = BYTE_CNT;
                     end
                     BYTE_CNT: s_nxt.byte_no = BYTE_DATA;
                     default: begin
                        if (s_r.blk_ok) begin
                           if (s_r.index == REG_CTRL) begin
                              s_nxt.sw_mode = s_r.sh[2:1];
                              s_nxt.sw_en   = s_r.sh[3];
                           end else if (s_r.index == REG_OE_LOW) begin
                              s_nxt.oe[7:0] = s_r.sh;
                           end else if (s_r.index == REG_OE_HIGH) begin
                              s_nxt.oe[11:8] = s_r.sh[3:0];
                           end
                        end
                        s_nxt.index = s_r.index + 7'h01;
                     end
                  endcase
               end
            end
            PH_RX_ACK: begin
               if (scl_fall) begin
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.sda_oe = 1'b0;
                  if (s_r.byte_no == BYTE_ADDR && s_r.rd) begin
                     s_nxt.phase   = PH_TX;
                     s_nxt.sh      = READ_COUNT;
                     s_nxt.byte_no = BYTE_DATA;
                     s_nxt.sda_oe  = ~READ_COUNT[7];
                  end else begin
                     s_nxt.phase = PH_RX;
                     if (s_r.byte_no == BYTE_ADDR) begin
                        s_nxt.byte_no = BYTE_CMD;
                     end
                  end
               end
            end
            PH_TX: begin
               if (scl_fall) begin
                  if (s_r.bitcnt == BITS_BYTE - 4'h1) begin
                     s_nxt.phase  = PH_TX_ACK;
                     s_nxt.sda_oe = 1'b0;
                  end else begin
                     s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                     s_nxt.sh     = {s_r.sh[6:0], 1'b0};
                     s_nxt.sda_oe = ~s_r.sh[6];
                  end
               end
            end
            PH_TX_ACK: begin
               // a nack ends the read; the host then stops
               if (scl_rise && s_r.sync2.sda) begin
                  s_nxt.phase = PH_IDLE;
               end else if (load_data) begin
                  s_nxt.phase  = PH_TX;
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.sh     = rd_v;
                  s_nxt.sda_oe = ~rd_v[7];
                  s_nxt.index  = s_r.index + 7'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_r         <= '0;
         s_r.sync1   <= '1;
         s_r.sync2   <= '1;
         s_r.prev    <= '1;
         s_r.sw_mode <= RST_SW_MODE;
         s_r.sw_en   <= RST_SW_EN;
         s_r.oe      <= RST_OE;
         s_r.phase   <= PH_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = s_r.sda_oe;
   assign cfg_out = '{diff_clock_output_en: s_r.oe,
                      pll_mode:             s_r.pll_mode,
                      frequency_select_bit: s_r.strap_fs};

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence byte_done;
      s_r.phase == PH_RX && scl_fall && s_r.bitcnt == BITS_BYTE
      && !start_c && !stop_c;
   endsequence
   sequence data_byte;
      byte_done ##0 s_r.byte_no == BYTE_DATA;
   endsequence

   write_ack_a: assert property (
      byte_done ##0 s_r.byte_no != BYTE_ADDR |=> s_r.sda_oe
      && s_r.phase == PH_RX_ACK)
      else $error("written byte not acknowledged");
   cmd_index_a: assert property (
      byte_done ##0 s_r.byte_no == BYTE_CMD
      |=> s_r.index == $past(s_r.sh[6:0]) && s_r.blk_ok == !$past(s_r.sh[7]))
      else $error("command byte did not set index");
   index_step_a: assert property (
      data_byte |=> s_r.index == $past(s_r.index) + 7'h01)
      else $error("index did not advance");
   oe_low_wr_a: assert property (
      data_byte ##0 s_r.blk_ok && s_r.index == REG_OE_LOW
      |=> ##1 cfg_out.diff_clock_output_en[7:0] == $past(s_r.sh, 2))
      else $error("low enables not written");
   count_first_a: assert property (
      s_r.phase == PH_RX_ACK && scl_fall && s_r.rd && !start_c && !stop_c
      && s_r.byte_no == BYTE_ADDR |=> s_r.phase == PH_TX
      && s_r.sh == READ_COUNT && s_r.sh != 8'h00 && s_r.sh <= BLK_CNT_MAX)
      else $error("byte count not sent first");
   pll_follow_a: assert property (
      s_r.captured |=> cfg_out.pll_mode == ($past(s_r.sw_en)
      ? $past(s_r.sw_mode) : $past(s_r.strap_pll)))
      else $error("pll mode source wrong");
   strap_hold_a: assert property (
      s_r.captured |=> $stable(s_r.strap_pll) && $stable(s_r.strap_fs))
      else $error("strap readback changed");
   rsvd_read_a: assert property (
      load_data && !start_c && !stop_c && !(scl_rise && s_r.sync2.sda)
      && s_r.index >= REG_OE_RB_LO |=> s_r.sh == 8'h00)
      else $error("reserved byte read nonzero");
   ctrl_rsvd_a: assert property (
      load_data && !start_c && !stop_c && s_r.index == REG_CTRL
      |=> s_r.sh[5:4] == 2'h0 && s_r.sh[7:6] == $past(s_r.strap_pll))
      else $error("control readback wrong");
endmodule : cbsr_regs

/* sim/cbsr_host.sv */
// smbus host controller model for the clock buffer register block
`timescale 1ns/1ps
module cbsr_host (
   input  wire logic           sda_oe,
   output cbsr_pkg::cbsr_bus_s bus
);
   import cbsr_pkg::*;
   localparam int HALF = 200;
   logic scl_r = 1'b1;
   logic sda_r = 1'b1;
   // pulled-up wire: low while either party pulls it
   assign bus = '{scl: scl_r, sda: sda_r & ~sda_oe};
   // start, also a repeated start from a low clock
   task automatic start();
      sda_r = 1'b1;
      #HALF scl_r = 1'b1;
      #HALF sda_r = 1'b0;
      #HALF scl_r = 1'b0;
   endtask : start
   task automatic stop();
      sda_r = 1'b0;
      #HALF scl_r = 1'b1;
      #HALF sda_r = 1'b1;
      #HALF;
   endtask : stop
   task automatic bit_io(input logic b, output logic s);
      sda_r = b;
      #HALF scl_r = 1'b1;
      #(HALF/2) s = bus.sda;
      #(HALF/2) scl_r = 1'b0;
   endtask : bit_io
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : put
   task automatic get(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask : get
endmodule : cbsr_host

/* sim/clock_buffer_smbus_block_regs_tb_top.sv */
// self-checking bench of the clock buffer smbus register block
`timescale 1ns/1ps
module clock_buffer_smbus_block_regs_tb_top;
   import cbsr_pkg::*;
   localparam logic [6:0] DEV_ADDR = 7'h35;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       fs_strap = 1'b1;
   logic [1:0] pll_strap = PLL_BYPASS;
   logic       sda_out;
   logic       sda_oe;
   cbsr_bus_s  bus;
   cbsr_cfg_s  cfg;
   int         failures = 0;
   int         check_count = 0;
   int         cycles = 0;
   always #5 sys_clk = ~sys_clk;
   cbsr_regs #(.SLAVE_ADDR(DEV_ADDR)) cbsr_regs_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .smbus_in(bus),
      .freq_select_strap(fs_strap), .pll_bandwidth_strap(pll_strap),
      .sda_out(sda_out), .sda_oe(sda_oe), .cfg_out(cfg));
   cbsr_host cbsr_host_inst (.sda_oe(sda_oe), .bus(bus));
   // ****************
   // shared tasks
   // ****************
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] cmd, input int n,
                     input logic [23:0] v);
      logic a;
      cbsr_host_inst.start();
      cbsr_host_inst.put({DEV_ADDR, 1'b0}, a);
      check("addr ack", 16'(a), 16'h1);
      cbsr_host_inst.put(cmd, a);
      check("cmd ack", 16'(a), 16'h1);
      cbsr_host_inst.put(8'(n), a);
      check("count ack", 16'(a), 16'h1);
      for (int i = n - 1; i >= 0; i--) begin
         cbsr_host_inst.put(v[8*i +: 8], a);
         check("data ack", 16'(a), 16'h1);
      end
      cbsr_host_inst.stop();
   endtask : wr
   task automatic rd(input logic [7:0] cmd, input logic [39:0] exp);
      logic       a;
      logic [7:0] d;
      cbsr_host_inst.start();
      cbsr_host_inst.put({DEV_ADDR, 1'b0}, a);
      check("addr ack", 16'(a), 16'h1);
      cbsr_host_inst.put(cmd, a);
      check("index ack", 16'(a), 16'h1);
      cbsr_host_inst.start();
      cbsr_host_inst.put({DEV_ADDR, 1'b1}, a);
      check("read addr ack", 16'(a), 16'h1);
      cbsr_host_inst.get(1'b0, d);
      check("count", 16'(d), 16'(READ_COUNT));
      check("count range", 16'(d > 8'h00 && d <= BLK_CNT_MAX), 16'h1);
      // take every byte that the count announced
      for (int i = int'(READ_COUNT) - 1; i >= 0; i--) begin
         cbsr_host_inst.get(i == 0, d);
         check("read data", 16'(d), 16'(exp[8*i +: 8]));
      end
      cbsr_host_inst.stop();
   endtask : rd
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      check("oe", 16'(cfg.diff_clock_output_en), 16'hFFF);
      check("fs", 16'(cfg.frequency_select_bit), 16'h1);
      check("pll", 16'(cfg.pll_mode), 16'(PLL_BYPASS));
      check("sda out", 16'(sda_out), 16'h0);
      rd(8'h00, 40'h47_FF_0F_00_00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_write();
      wr(8'h00, 3, 24'hF8_5A_F3);
      check("pll sw", 16'(cfg.pll_mode), 16'(PLL_NARROW));
      check("fs kept", 16'(cfg.frequency_select_bit), 16'h1);
      check("oe", 16'(cfg.diff_clock_output_en), 16'h35A);
      rd(8'h00, 40'h49_5A_03_00_00);
      $display("test write done");
   endtask : t_write
   task automatic t_modes();
      logic [1:0] m [3] = '{PLL_NARROW, PLL_BYPASS, PLL_WIDE};
      foreach (m[i]) begin
         wr(8'h00, 1, {16'h0000, 4'h0, 1'b1, m[i], 1'b0});
         check("pll mode", 16'(cfg.pll_mode), 16'(m[i]));
      end
      wr(8'h00, 1, 24'h000006);
      check("pll strap", 16'(cfg.pll_mode), 16'(PLL_BYPASS));
      $display("test modes done");
   endtask : t_modes
   task automatic t_strap();
      @(negedge sys_clk);
      fs_strap  = 1'b0;
      pll_strap = PLL_WIDE;
      reset_n   = 1'b0;
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (10) @(negedge sys_clk);
      check("oe rst", 16'(cfg.diff_clock_output_en), 16'hFFF);
      check("fs strap", 16'(cfg.frequency_select_bit), 16'h0);
      check("pll wide", 16'(cfg.pll_mode), 16'(PLL_WIDE));
      rd(8'h00, 40'hC6_FF_0F_00_00);
      $display("test strap done");
   endtask : t_strap
   task automatic t_index();
      logic a;
      wr(8'h01, 2, 24'h00_00_AA);
      check("oe", 16'(cfg.diff_clock_output_en), 16'hA00);
      wr(8'h03, 2, 24'h00_FF_FF);
      rd(8'h02, 40'h0A_00_00_00_00);
      cbsr_host_inst.start();
      cbsr_host_inst.put({~DEV_ADDR, 1'b0}, a);
      check("foreign addr nack", 16'(a), 16'h0);
      cbsr_host_inst.stop();
      $display("test index done");
   endtask : t_index
   initial begin
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (10) @(negedge sys_clk);
      t_reset();
      t_write();
      t_modes();
      t_strap();
      t_index();
      conclude();
   end
   // hang guard, far above the length of all scenarios
   always @(negedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         $display("timeout after %0d cycles", cycles);
         conclude();
      end
   end
endmodule : clock_buffer_smbus_block_regs_tb_top
